// ---- rtl/can_object_status_vectors.sv ----
// Message object status vectors with an Avalon-MM register slave
//
// Contract
// - Upper transmit vector shows objects 17..32.
// - Transmit flags read only, writes ignored.
// - Fresh flag updated by window or handler.
// - Two fresh vectors hold objects 1..32.
// - Zero fresh flag means nothing new stored.
// - Irq flag updated by window or handler.
// - Irq flag changes update interrupt source id.
// - Lower irq vector shows objects 1..16.
// - Reserved upper bits read zero, writes ignored.
// - Bit 0 of lower vector is object 1.
// - Store holds 32 objects, window access only.
//
// The implementer's own choice: the Avalon-MM interface to the registers.
`timescale 1ns/1ps

module can_object_status_vectors
    import can_status_pkg::*;
(
    input  wire logic                 REF_CLK_IN,          // 10 MHz clock
    input  wire logic                 SYS_RST_IN,          // Sync reset, high
    input  wire logic [ADDR_W-1:0]    AVS_ADDRESS_IN,      // Byte address
    input  wire logic                 AVS_READ_IN,         // Read request
    input  wire logic                 AVS_WRITE_IN,        // Write request
    input  wire logic [DATA_W-1:0]    AVS_WRITEDATA_IN,    // Write data
    output logic      [DATA_W-1:0]    AVS_READDATA_OUT,    // Read data
    output logic                      AVS_WAITREQUEST_OUT, // Slave stall
    input  wire handler_evt_t         HANDLER_EVT_IN,      // Handler events
    input  wire window_upd_t          WINDOW_UPD_IN,       // Window update
    output logic      [OBJ_COUNT-1:0] TX_PENDING_OUT,      // All tx flags
    output logic      [SRC_ID_W-1:0]  INT_SOURCE_ID_OUT,   // Lowest irq obj
    output logic                      IRQ_OUT              // Level interrupt
);

    // ************************************************************
    // State
    // ************************************************************
    logic [OBJ_COUNT-1:0] tx_flag_q;          // Transmit pending flags
    logic [OBJ_COUNT-1:0] tx_flag_d;          // Next transmit flags
    logic [OBJ_COUNT-1:0] fresh_flag_q;       // Fresh payload flags
    logic [OBJ_COUNT-1:0] fresh_flag_d;       // Next fresh flags
    logic [OBJ_COUNT-1:0] irq_flag_q;         // Object irq flags
    logic [OBJ_COUNT-1:0] irq_flag_d;         // Next object irq flags
    logic [EVT_W-1:0]     evt_status_q;       // Sticky event bits
    logic [EVT_W-1:0]     evt_status_d;       // Next sticky bits
    logic [EVT_W-1:0]     evt_mask_q;         // Event enable mask
    logic [EVT_W-1:0]     evt_mask_d;         // Next mask
    logic [SRC_ID_W-1:0]  src_id_q;           // Registered source id
    logic [SRC_ID_W-1:0]  src_id_d;           // Lowest pending object
    logic [DATA_W-1:0]    rdata_q;            // Read data register
    logic [DATA_W-1:0]    rdata_d;            // Selected read data
    logic                 wait_q;             // Waitrequest register
    logic                 wait_d;             // Next waitrequest
    logic                 irq_q;              // Interrupt output register

    // ************************************************************
    // Bus decode
    // ************************************************************
    // A request is accepted in the cycle where waitrequest is low;
    // the slave lowers it for exactly one cycle per request.
    wire bus_req      = AVS_READ_IN | AVS_WRITE_IN;  // Any request
    wire rd_accept    = AVS_READ_IN & ~wait_q;       // Read accepted
    wire wr_accept    = AVS_WRITE_IN & ~wait_q;      // Write accepted
    wire sel_tx_up    = (AVS_ADDRESS_IN == OFF_TX_PEND_UP);
    wire sel_fresh_lo = (AVS_ADDRESS_IN == OFF_FRESH_LO);
    wire sel_fresh_up = (AVS_ADDRESS_IN == OFF_FRESH_UP);
    wire sel_irq_lo   = (AVS_ADDRESS_IN == OFF_IRQ_PEND_LO);
    wire sel_status   = (AVS_ADDRESS_IN == OFF_EVT_STATUS);
    wire sel_mask     = (AVS_ADDRESS_IN == OFF_EVT_MASK);
    wire sel_src_id   = (AVS_ADDRESS_IN == OFF_SRC_ID);

    // Status is cleared by the read that the master actually takes
    wire status_rd_clr = rd_accept & sel_status;      // Read clears
    // Only the mask takes writes; the vectors ignore them
    wire mask_wr       = wr_accept & sel_mask;

    // Zero-extended views of each readable register
    wire [DATA_W-1:0] rd_tx_up    = {{(DATA_W-HALF_COUNT){1'b0}},
                                     tx_flag_q[OBJ_COUNT-1:HALF_COUNT]};
    wire [DATA_W-1:0] rd_fresh_lo = {{(DATA_W-HALF_COUNT){1'b0}},
                                     fresh_flag_q[HALF_COUNT-1:0]};
    wire [DATA_W-1:0] rd_fresh_up = {{(DATA_W-HALF_COUNT){1'b0}},
                                     fresh_flag_q[OBJ_COUNT-1:HALF_COUNT]};
    wire [DATA_W-1:0] rd_irq_lo   = {{(DATA_W-HALF_COUNT){1'b0}},
                                     irq_flag_q[HALF_COUNT-1:0]};
    wire [DATA_W-1:0] rd_status   = {{(DATA_W-EVT_W){1'b0}},
                                     evt_status_q};
    wire [DATA_W-1:0] rd_mask     = {{(DATA_W-EVT_W){1'b0}}, evt_mask_q};
    wire [DATA_W-1:0] rd_src_id   = {{(DATA_W-SRC_ID_W){1'b0}},
                                     src_id_q};

    // ************************************************************
    // Read data select
    // ************************************************************
    // Bits [31:16] of every vector come back zero; unmapped reads
    // return all zeros rather than an error.
    always_comb begin
        rdata_d = RDATA_RST;                          // Unmapped reads
        if (sel_tx_up) begin
            rdata_d = rd_tx_up;
        end
        else if (sel_fresh_lo) begin
            rdata_d = rd_fresh_lo;
        end
        else if (sel_fresh_up) begin
            rdata_d = rd_fresh_up;
        end
        else if (sel_irq_lo) begin
            rdata_d = rd_irq_lo;
        end
        else if (sel_status) begin
            rdata_d = rd_status;                      // Sticky events
        end
        else if (sel_mask) begin
            rdata_d = rd_mask;                        // Event mask
        end
        else if (sel_src_id) begin
            rdata_d = rd_src_id;                      // Source id
        end
    end

    // ************************************************************
    // Waitrequest sequencing
    // ************************************************************
    // Idle high; drops for one cycle after a request is seen, then
    // rises again so back-to-back requests each take two cycles.
    // This costs a cycle per access but keeps read data registered.
    always_comb begin
        wait_d = 1'b1;                                // Default stall
        if (bus_req && wait_q) begin
            wait_d = 1'b0;                            // Answer next cycle
        end
    end

    // ************************************************************
    // Per-object flag update
    // ************************************************************
    // A window update writes its chosen flags of one object; a
    // handler set wins over everything, and a handler clear wins
    // over a window write, so no hardware event is ever lost.
    genvar gi;
    generate
        for (gi = 0; gi < OBJ_COUNT; gi++) begin : g_obj
            // Window hits this object
            wire hit = WINDOW_UPD_IN.valid &&
                       (WINDOW_UPD_IN.obj == OBJ_IDX_W'(gi));
            // Window value or hold, per flag
            wire tx_win    = (hit && WINDOW_UPD_IN.upd_tx) ?
                             WINDOW_UPD_IN.tx_val : tx_flag_q[gi];
            wire fresh_win = (hit && WINDOW_UPD_IN.upd_fresh) ?
                             WINDOW_UPD_IN.fresh_val : fresh_flag_q[gi];
            wire irq_win   = (hit && WINDOW_UPD_IN.upd_irq) ?
                             WINDOW_UPD_IN.irq_val : irq_flag_q[gi];
            // Transmit flag: set beats clear beats window
            assign tx_flag_d[gi] = HANDLER_EVT_IN.tx_set[gi] |
                                   (~HANDLER_EVT_IN.tx_clr[gi] &
                                    tx_win);
            // Fresh payload flag, same priority
            assign fresh_flag_d[gi] = HANDLER_EVT_IN.fresh_set[gi] |
                                      (~HANDLER_EVT_IN.fresh_clr[gi] &
                                       fresh_win);
            // Object irq flag, same priority
            assign irq_flag_d[gi] = HANDLER_EVT_IN.irq_set[gi] |
                                    (~HANDLER_EVT_IN.irq_clr[gi] &
                                     irq_win);
        end
    endgenerate

    // ************************************************************
    // Interrupt source id
    // ************************************************************
    // Lowest numbered object with its irq flag set, counted from 1;
    // zero when no object is pending. Follows the next flag value so
    // the id moves in the same cycle the flag does.
    always_comb begin
        src_id_d = SRC_ID_NONE;                       // No source
        for (int i = OBJ_COUNT - 1; i >= 0; i--) begin
            if (irq_flag_d[i]) begin
                src_id_d = SRC_ID_W'(i + 1);
            end
        end
    end

    // ************************************************************
    // Event status and mask
    // ************************************************************
    // Edges of the flag vectors raise sticky bits. A new event in the
    // cycle of a clearing read is kept, since set wins over clear.
    wire fresh_rise = |(fresh_flag_d & ~fresh_flag_q);   // Payload came
    wire tx_fall    = |(~tx_flag_d & tx_flag_q);         // Sent or dropped
    wire irq_rise   = |(irq_flag_d & ~irq_flag_q);       // Irq raised
    wire [EVT_W-1:0] evt_now = {irq_rise, tx_fall, fresh_rise};

    always_comb begin
        evt_status_d = evt_status_q | evt_now;        // Set wins
        if (status_rd_clr) begin
            evt_status_d = evt_now;                   // Clear on read
        end
        evt_mask_d = evt_mask_q;                      // Hold mask
        if (mask_wr) begin
            evt_mask_d = AVS_WRITEDATA_IN[EVT_W-1:0]; // Mask write
        end
    end

    // Interrupt level computed from next values for a flop output
    wire irq_d = |(evt_status_d & evt_mask_d);        // Unmasked pending

    // ************************************************************
    // Flag registers
    // ************************************************************
    // All vectors clear on reset; bus writes never touch them.
    always_ff @(posedge REF_CLK_IN) begin
        if (SYS_RST_IN) begin
            tx_flag_q    <= FLAGS_RST;
            fresh_flag_q <= FLAGS_RST;
            irq_flag_q   <= FLAGS_RST;
        end
        else begin
            tx_flag_q    <= tx_flag_d;                // Flag update
            fresh_flag_q <= fresh_flag_d;             // Flag update
            irq_flag_q   <= irq_flag_d;               // Flag update
        end
    end

    // ************************************************************
    // Interrupt registers
    // ************************************************************
    always_ff @(posedge REF_CLK_IN) begin
        if (SYS_RST_IN) begin
            evt_status_q <= EVT_RST;                  // No events
            evt_mask_q   <= EVT_RST;                  // All masked
            src_id_q     <= SRC_ID_NONE;              // No source
            irq_q        <= 1'b0;                     // Quiet
        end
        else begin
            evt_status_q <= evt_status_d;             // Sticky bits
            evt_mask_q   <= evt_mask_d;               // Mask
            src_id_q     <= src_id_d;
            irq_q        <= irq_d;                    // Output level
        end
    end

    // ************************************************************
    // Bus registers
    // ************************************************************
    // Read data is sampled while waitrequest is still high, so it is
    // stable in the one cycle the master takes it; at the accept edge
    // it returns to zero so it never shows while waitrequest is high.
    always_ff @(posedge REF_CLK_IN) begin
        if (SYS_RST_IN) begin
            wait_q  <= 1'b1;                          // Stall idle
            rdata_q <= RDATA_RST;                     // Zero data
        end
        else begin
            wait_q  <= wait_d;
            if (bus_req && wait_q) begin
                rdata_q <= rdata_d;                   // Capture read
            end
            else begin
                rdata_q <= RDATA_RST;                 // Idle zero
            end
        end
    end

    // ************************************************************
    // Outputs
    // ************************************************************
    assign AVS_READDATA_OUT    = rdata_q;             // Registered
    assign AVS_WAITREQUEST_OUT = wait_q;              // Registered
    assign TX_PENDING_OUT      = tx_flag_q;           // Registered
    assign INT_SOURCE_ID_OUT   = src_id_q;            // Registered
    assign IRQ_OUT             = irq_q;               // Registered

endmodule // can_object_status_vectors

// ---- rtl/can_status_pkg.sv ----
// Constants and carrier types for the message object status vectors
package can_status_pkg;

    // ************************************************************
    // Sizes
    // ************************************************************
    localparam int OBJ_COUNT   = 32;          // Objects in the message store
    localparam int HALF_COUNT  = 16;          // Objects per status vector
    localparam int ADDR_W      = 9;           // Byte address width
    localparam int DATA_W      = 32;          // Bus data width
    localparam int OBJ_IDX_W   = 5;           // Zero-based object index
    localparam int SRC_ID_W    = 6;           // Source id, 0 means none
    localparam int EVT_W       = 3;           // Sticky event bits

    // ************************************************************
    // Register byte offsets
    // ************************************************************
    localparam logic [ADDR_W-1:0] OFF_TX_PEND_UP  = 9'h104;
    localparam logic [ADDR_W-1:0] OFF_FRESH_LO    = 9'h120;
    localparam logic [ADDR_W-1:0] OFF_FRESH_UP    = 9'h124;
    localparam logic [ADDR_W-1:0] OFF_IRQ_PEND_LO = 9'h140;
    localparam logic [ADDR_W-1:0] OFF_EVT_STATUS  = 9'h180;
    localparam logic [ADDR_W-1:0] OFF_EVT_MASK    = 9'h184;
    localparam logic [ADDR_W-1:0] OFF_SRC_ID      = 9'h188;

    // ************************************************************
    // Reset values and event bit positions
    // ************************************************************
    localparam logic [OBJ_COUNT-1:0] FLAGS_RST    = 32'h0000_0000;
    localparam logic [DATA_W-1:0]    RDATA_RST    = 32'h0000_0000;
    localparam logic [EVT_W-1:0]     EVT_RST      = 3'h0;
    localparam logic [SRC_ID_W-1:0]  SRC_ID_NONE  = 6'h00;
    localparam int EVT_FRESH_BIT = 0;         // A fresh payload flag rose
    localparam int EVT_TXDONE_BIT = 1;        // A transmit request cleared
    localparam int EVT_IRQ_BIT   = 2;         // An object irq flag rose

    // ************************************************************
    // Carrier types
    // ************************************************************
    // Per-object set and clear requests from the message handler
    typedef struct packed {
        logic [OBJ_COUNT-1:0] tx_set;         // Transmit request raised
        logic [OBJ_COUNT-1:0] tx_clr;         // Transmission finished
        logic [OBJ_COUNT-1:0] fresh_set;      // Payload stored
        logic [OBJ_COUNT-1:0] fresh_clr;      // Payload consumed
        logic [OBJ_COUNT-1:0] irq_set;        // Object raises irq
        logic [OBJ_COUNT-1:0] irq_clr;        // Object drops irq
    } handler_evt_t;

    // One object update through the object access window
    typedef struct packed {
        logic                 valid;          // Update strobe
        logic [OBJ_IDX_W-1:0] obj;            // Zero-based object index
        logic                 upd_tx;         // Write transmit flag
        logic                 upd_fresh;      // Write fresh payload flag
        logic                 upd_irq;        // Write object irq flag
        logic                 tx_val;         // New transmit flag value
        logic                 fresh_val;      // New fresh payload value
        logic                 irq_val;        // New object irq value
    } window_upd_t;

endpackage : can_status_pkg

// ---- bench/can_status_monitor.sv ----
// Concurrent checks on the ports of the message object status vectors
`timescale 1ns/1ps
module can_status_monitor
    import can_status_pkg::*;
(
    input wire logic                 REF_CLK_IN,          // Clock
    input wire logic                 SYS_RST_IN,          // Reset, high
    input wire logic [ADDR_W-1:0]    AVS_ADDRESS_IN,      // Byte address
    input wire logic                 AVS_READ_IN,         // Read request
    input wire logic                 AVS_WRITE_IN,        // Write request
    input wire logic [DATA_W-1:0]    AVS_WRITEDATA_IN,    // Write data
    input wire logic [DATA_W-1:0]    AVS_READDATA_OUT,    // Read data
    input wire logic                 AVS_WAITREQUEST_OUT, // Slave stall
    input wire handler_evt_t         HANDLER_EVT_IN,      // Handler events
    input wire window_upd_t          WINDOW_UPD_IN,       // Window update
    input wire logic [OBJ_COUNT-1:0] TX_PENDING_OUT,      // Tx flags
    input wire logic [SRC_ID_W-1:0]  INT_SOURCE_ID_OUT,   // Source id
    input wire logic                 IRQ_OUT              // Interrupt
);
    // ************************************************************
    // Helper history, kept as registers to avoid $past of slices
    // ************************************************************
    logic [15:0]          tx_up_q;   // Upper transmit flags last cycle
    logic [OBJ_COUNT-1:0] tx_set_q;  // Handler sets last cycle
    logic [OBJ_COUNT-1:0] tx_clr_q;  // Clears not overridden by a set
    // History follows the ports every edge
    always_ff @(posedge REF_CLK_IN) begin
        tx_up_q  <= TX_PENDING_OUT[31:16];
        tx_set_q <= HANDLER_EVT_IN.tx_set;
        tx_clr_q <= HANDLER_EVT_IN.tx_clr & ~HANDLER_EVT_IN.tx_set;
    end
    // ************************************************************
    // Bus steps and checks
    // ************************************************************
    default clocking cb @(posedge REF_CLK_IN); endclocking
    default disable iff (SYS_RST_IN);
    sequence bus_seen;
        (AVS_READ_IN || AVS_WRITE_IN) && AVS_WAITREQUEST_OUT;
    endsequence
    sequence bus_done;
        !AVS_WAITREQUEST_OUT;
    endsequence
    sequence rd_done(a);
        bus_done ##0 (AVS_READ_IN && AVS_ADDRESS_IN == a);
    endsequence
    chk_wait_once: assert property (bus_seen |=> bus_done)
        else $error("waitrequest not low one cycle after request");
    chk_wait_pulse: assert property (bus_done |=>
        AVS_WAITREQUEST_OUT)
        else $error("waitrequest low for more than one cycle");
    chk_idle_zero: assert property (AVS_WAITREQUEST_OUT |->
        AVS_READDATA_OUT == RDATA_RST)
        else $error("read data not zero while idle");
    chk_rsvd_zero: assert property (bus_done ##0 AVS_READ_IN |->
        AVS_READDATA_OUT[31:16] == 16'h0000)
        else $error("upper read data bits not zero");
    chk_tx_view: assert property (rd_done(OFF_TX_PEND_UP) |->
        AVS_READDATA_OUT[15:0] == tx_up_q)
        else $error("upper transmit vector read wrong");
    chk_tx_ro: assert property (bus_done ##0 AVS_WRITE_IN &&
        HANDLER_EVT_IN.tx_set == '0 && HANDLER_EVT_IN.tx_clr == '0 &&
        !WINDOW_UPD_IN.valid |=> $stable(TX_PENDING_OUT))
        else $error("bus write changed transmit flags");
    chk_tx_set: assert property (|HANDLER_EVT_IN.tx_set |=>
        (TX_PENDING_OUT & tx_set_q) == tx_set_q)
        else $error("handler transmit set not seen");
    chk_tx_clr: assert property (|tx_clr_q |->
        (TX_PENDING_OUT & tx_clr_q) == '0)
        else $error("handler transmit clear not seen");
    chk_src_first: assert property (HANDLER_EVT_IN.irq_set[0] |=>
        INT_SOURCE_ID_OUT == 6'h01)
        else $error("source id not object one");
endmodule // can_status_monitor

bind can_object_status_vectors can_status_monitor mon (
    .REF_CLK_IN(REF_CLK_IN), .SYS_RST_IN(SYS_RST_IN),
    .AVS_ADDRESS_IN(AVS_ADDRESS_IN), .AVS_READ_IN(AVS_READ_IN),
    .AVS_WRITE_IN(AVS_WRITE_IN), .AVS_WRITEDATA_IN(AVS_WRITEDATA_IN),
    .AVS_READDATA_OUT(AVS_READDATA_OUT),
    .AVS_WAITREQUEST_OUT(AVS_WAITREQUEST_OUT),
    .HANDLER_EVT_IN(HANDLER_EVT_IN), .WINDOW_UPD_IN(WINDOW_UPD_IN),
    .TX_PENDING_OUT(TX_PENDING_OUT), .INT_SOURCE_ID_OUT(INT_SOURCE_ID_OUT),
    .IRQ_OUT(IRQ_OUT)
);

// ---- bench/can_handler_model.sv ----
// Behavioural message handler and object window feeding the flag inputs
`timescale 1ns/1ps
module can_handler_model
    import can_status_pkg::*;
(
    input  wire logic   clk_in,   // Block clock
    output handler_evt_t evt_out, // Handler events
    output window_upd_t  win_out  // Window update
);
    // Quiet until asked: no event and no window strobe
    initial begin
        evt_out = '0;
        win_out = '0;
    end
    // One cycle of handler events and one window write, then quiet again
    task automatic pulse(input handler_evt_t e, input window_upd_t w);
        @(posedge clk_in);
        evt_out <= e;
        win_out <= w;
        @(posedge clk_in);
        evt_out <= '0;
        win_out <= '0;
    endtask
endmodule // can_handler_model

// ---- bench/can_object_status_vectors_tb.sv ----
// Self-checking bench for the message object status vectors
`timescale 1ns/1ps
module can_object_status_vectors_tb;
    import can_status_pkg::*;
    typedef struct packed {
        logic [1:0]        kind;  // 0 tx, 1 fresh, 2 irq, 3 none
        logic [4:0]        obj;   // Zero-based object index
        logic [ADDR_W-1:0] addr;  // Register read back
        logic [DATA_W-1:0] exp;   // Expected read data
    } row_t;
    logic ref_clk = 1'b0, sys_rst = 1'b1, rd = 1'b0, wr = 1'b0;
    logic [ADDR_W-1:0] addr = '0;          // Bus address
    logic [DATA_W-1:0] wdata = '0, rdata, q; // Bus data
    logic waitreq, irq;                    // Stall and interrupt
    logic [OBJ_COUNT-1:0] tx_pend;         // All transmit flags
    logic [SRC_ID_W-1:0]  src_id;          // Lowest irq object
    handler_evt_t evt, ev;                 // Model output, built event
    window_upd_t  win, w;                  // Model output, built update
    int err_count = 0, comparisons = 0, cycles = 0;
    row_t rows [12] = '{'{2'h0, 5'h10, OFF_TX_PEND_UP, 32'h0000_0001},
        '{2'h0, 5'h1F, OFF_TX_PEND_UP, 32'h0000_8000},
        '{2'h0, 5'h00, OFF_TX_PEND_UP, 32'h0000_0000},
        '{2'h1, 5'h00, OFF_FRESH_LO, 32'h0000_0001},
        '{2'h1, 5'h0F, OFF_FRESH_LO, 32'h0000_8000},
        '{2'h1, 5'h10, OFF_FRESH_UP, 32'h0000_0001},
        '{2'h1, 5'h1F, OFF_FRESH_UP, 32'h0000_8000},
        '{2'h2, 5'h00, OFF_IRQ_PEND_LO, 32'h0000_0001},
        '{2'h2, 5'h0F, OFF_IRQ_PEND_LO, 32'h0000_8000},
        '{2'h2, 5'h10, OFF_IRQ_PEND_LO, 32'h0000_0000},
        '{2'h2, 5'h04, OFF_SRC_ID, 32'h0000_0005},
        '{2'h3, 5'h00, 9'h1FC, 32'h0000_0000}};
    always #50 ref_clk = ~ref_clk;
    can_object_status_vectors uut (.REF_CLK_IN(ref_clk), .SYS_RST_IN(sys_rst),
        .AVS_ADDRESS_IN(addr), .AVS_READ_IN(rd), .AVS_WRITE_IN(wr),
        .AVS_WRITEDATA_IN(wdata), .AVS_READDATA_OUT(rdata),
        .AVS_WAITREQUEST_OUT(waitreq), .HANDLER_EVT_IN(evt),
        .WINDOW_UPD_IN(win), .TX_PENDING_OUT(tx_pend),
        .INT_SOURCE_ID_OUT(src_id), .IRQ_OUT(irq));
    can_handler_model m (.clk_in(ref_clk), .evt_out(evt), .win_out(win));
    // ************************************************************
    // Shared tasks
    // ************************************************************
    // Held until the edge that sees waitrequest low; data taken there
    task automatic bus(input logic we, input logic [8:0] a,
                       input logic [31:0] d, output logic [31:0] r);
        @(posedge ref_clk);
        rd <= ~we; wr <= we; addr <= a; wdata <= d;
        @(posedge ref_clk);
        while (waitreq !== 1'b0) @(posedge ref_clk);
        r = rdata;
        rd <= 1'b0; wr <= 1'b0;
    endtask
    task automatic check(input string nm, input logic [31:0] s, e);
        comparisons++;
        if (s !== e) begin
            err_count++;
            $display("unexpected %s expected %h seen %h", nm, e, s);
        end
    endtask
    // Handler clears every flag in one cycle
    task automatic clear_all();
        ev = '0; ev.tx_clr = '1; ev.fresh_clr = '1; ev.irq_clr = '1;
        m.pulse(ev, '0);
    endtask
    task automatic test_done();
        $display("checks %0d mismatches %0d", comparisons, err_count);
        if (err_count == 0 && comparisons > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask
    // Hang guard, far above the roughly 180 cycles the run needs
    always @(posedge ref_clk) begin
        cycles++;
        if (cycles == 3000) begin
            err_count++;
            test_done();
        end
    end
    initial begin
        repeat (5) @(posedge ref_clk);
        sys_rst <= 1'b0;
        foreach (rows[i]) begin
            bus(1'b0, rows[i].addr, '0, q);
            check("reset read", q, 32'h0000_0000);
        end
        // Table: at most one flag raised, then the row's register read back
        foreach (rows[i]) begin
            clear_all();
            ev = '0;
            case (rows[i].kind)
                2'h0: ev.tx_set[rows[i].obj] = 1'b1;
                2'h1: ev.fresh_set[rows[i].obj] = 1'b1;
                2'h2: ev.irq_set[rows[i].obj] = 1'b1;
                default: ;
            endcase
            m.pulse(ev, '0);
            bus(1'b0, rows[i].addr, '0, q);
            check("row read", q, rows[i].exp);
        end
        // Writes of ones to read-only flag bits change nothing;
        // reserved bits are written zero as software must
        clear_all();
        ev = '0; ev.tx_set[19] = 1'b1;
        m.pulse(ev, '0);
        bus(1'b1, OFF_TX_PEND_UP, 32'h0000_FFFF, q);
        bus(1'b1, OFF_FRESH_UP, 32'h0000_FFFF, q);
        bus(1'b0, OFF_TX_PEND_UP, '0, q);
        check("tx upper", q, 32'h0000_0008);
        check("tx port", tx_pend, 32'h0008_0000);
        bus(1'b0, OFF_FRESH_UP, '0, q);
        check("fresh upper", q, 32'h0000_0000);
        // Window sets then clears, then loses to a handler set
        w = '0; w.valid = 1'b1; w.obj = 5'h02; w.upd_fresh = 1'b1;
        w.fresh_val = 1'b1;
        m.pulse('0, w);
        bus(1'b0, OFF_FRESH_LO, '0, q);
        check("window set", q, 32'h0000_0004);
        w.fresh_val = 1'b0;
        m.pulse('0, w);
        bus(1'b0, OFF_FRESH_LO, '0, q);
        check("window clear", q, 32'h0000_0000);
        ev = '0; ev.fresh_set[2] = 1'b1;
        m.pulse(ev, w);
        bus(1'b0, OFF_FRESH_LO, '0, q);
        check("handler wins", q, 32'h0000_0004);
        w = '0; w.valid = 1'b1; w.obj = 5'h06; w.upd_irq = 1'b1;
        w.irq_val = 1'b1;
        m.pulse('0, w);
        bus(1'b0, OFF_SRC_ID, '0, q);
        check("window irq id", q, 32'h0000_0007);
        // Interrupt raised, read-cleared, then masked
        clear_all();
        bus(1'b0, OFF_EVT_STATUS, '0, q);
        check("status all", q, 32'h0000_0007);
        bus(1'b1, OFF_EVT_MASK, 32'h0000_0004, q);
        ev = '0; ev.irq_set[1] = 1'b1;
        m.pulse(ev, '0);
        @(negedge ref_clk);
        check("irq raised", irq, 1'b1);
        bus(1'b0, OFF_EVT_STATUS, '0, q);
        check("status", q, 32'h0000_0004);
        @(negedge ref_clk);
        check("irq cleared", irq, 1'b0);
        bus(1'b1, OFF_EVT_MASK, 32'h0000_0001, q);
        ev = '0; ev.irq_set[2] = 1'b1;
        m.pulse(ev, '0);
        @(negedge ref_clk);
        check("irq masked", irq, 1'b0);
        bus(1'b0, OFF_SRC_ID, '0, q);
        check("lowest id", q, 32'h0000_0002);
        test_done();
    end
endmodule // can_object_status_vectors_tb
